/* File: hw/irp_map.vh */
// constants and register map of the interrupt, reset and port block
// Functional notes
// [RULE1] return reloads pc and flags from stack
// [RULE2] return sets master enable to one
// [RULE3] only pc and flags saved, nothing else
// [RULE4] falling pin edge sets request latch
// [RULE5] driver holds each level two cycles
// [RULE6] high priority irq needs master enable only
// [RULE7] sense pin falling edge raises high irq
// [RULE8] reset pin low three cycles resets
// [RULE9] after reset fetch starts at 000
// [RULE10] reset clears enable, latches; sets status
// [RULE11] reset clears mask and interval counter
// [RULE12] one port address space selects port
// [RULE13] input sampled in phase three, cycle two
// [RULE14] output updates in phase four, cycle two
// [RULE15] outputs latched, inputs read live pins
// [RULE16] keep input stable until read
// [RULE17] four ports, eleven pins, 4-bit at 04/05
// [RULE18] sense input shares standby pin, read only
// [RULE19] 2-bit port at 08 shares irq pin
// [RULE20] accept pushes, vectors, sets status, clears
// [RULE21] sense input reads inverted pin level
// [RULE22] unassigned port writes ignored
// [RULE23] bit set/clear touches addressed bit only
`ifndef IRP_MAP_VH
`define IRP_MAP_VH
`define IRP_ADDR_LED      5'h04
`define IRP_ADDR_GEN      5'h05
`define IRP_ADDR_SHR      5'h08
`define IRP_ADDR_SENSE    5'h0E
`define IRP_PORT_RST4     4'hF
`define IRP_PORT_RST2     2'h3
`define IRP_PC_RESET      11'h000
`define IRP_VEC_HIGH      11'h002
`define IRP_VEC_TC1       11'h006
`define IRP_VEC_TC2       11'h008
`define IRP_VEC_ITMR      11'h00A
`define IRP_VEC_LOW       11'h00C
`define IRP_RST_CYCLES    2'h3
`define IRP_PHASES        2'h3
`define IRP_PH_SAMPLE     2'h2
`define IRP_PH_UPDATE     2'h3
`define IRP_IL_HIGH       5
`define IRP_IL_TC1        3
`define IRP_IL_TC2        2
`define IRP_IL_ITMR       1
`define IRP_IL_LOW        0
`define IRP_STACK_DEPTH   16
`define IRP_OP_NONE       2'h0
`define IRP_OP_IN         2'h1
`define IRP_OP_OUT        2'h2
`define IRP_OP_BIT        2'h3
`endif

/* File: hw/irp_sync_edge.v */
// two-stage synchroniser with falling edge detector
`timescale 1ns/1ps
module irp_sync_edge (
    input  wire clk_i,
    input  wire reset_i,
    input  wire pin_i,
    output wire level_o,
    output wire fall_o
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    always @(posedge clk_i) begin
        if (reset_i) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    assign level_o = s2_q;
    assign fall_o  = s3_q & ~s2_q; // RULE4
endmodule // irp_sync_edge

/* File: hw/irp_reset_qual.v */
// reset pin qualifier: low for three cycles gives internal reset
`timescale 1ns/1ps
`include "irp_map.vh"
module irp_reset_qual (
    input  wire clk_i,
    input  wire reset_i,
    input  wire reset_pin_n_i,
    output reg  core_rst_o
);
    reg       s1_q;
    reg       s2_q;
    reg [1:0] cnt_q;
    always @(posedge clk_i) begin
        if (reset_i) begin
            s1_q       <= 1'b1;
            s2_q       <= 1'b1;
            cnt_q      <= 2'h0;
            core_rst_o <= 1'b1;
        end else begin
            s1_q <= reset_pin_n_i;
            s2_q <= s1_q;
            if (s2_q) begin
                cnt_q      <= 2'h0;
                core_rst_o <= 1'b0; // RULE9
            end else if (cnt_q != `IRP_RST_CYCLES - 2'h1) begin
                cnt_q <= cnt_q + 2'h1;
            end else begin
                core_rst_o <= 1'b1; // RULE8
            end
        end
    end
endmodule // irp_reset_qual

/* File: hw/irp_core.v */
// interrupt, reset and port-address i/o control core
`timescale 1ns/1ps
`include "irp_map.vh"
module irp_core (
    input  wire        clk_i,
    input  wire        reset_i,
    input  wire        reset_pin_n_i,
    input  wire [1:0]  op_i,
    input  wire [4:0]  port_addr_i,
    input  wire [3:0]  wr_data_i,
    input  wire [1:0]  bit_sel_i,
    input  wire        bit_val_i,
    input  wire        instr_end_i,
    input  wire        return_from_irq_instr_i,
    input  wire [10:0] pc_i,
    input  wire [1:0]  flags_i,
    input  wire        ilclr_i,
    input  wire [5:0]  ilclr_keep_i,
    input  wire        eif_set_i,
    input  wire        eif_clr_i,
    input  wire        mask_wr_i,
    input  wire [3:0]  mask_data_i,
    input  wire        tc1_ovf_i,
    input  wire        tc2_ovf_i,
    input  wire        itmr_tick_i,
    input  wire [3:0]  led_pin_i,
    input  wire [3:0]  gen_pin_i,
    input  wire [1:0]  shr_pin_i,
    input  wire        sense_pin_i,
    output reg  [3:0]  led_out_o,
    output reg  [3:0]  led_oe_n_o,
    output reg  [3:0]  gen_out_o,
    output reg  [3:0]  gen_oe_n_o,
    output reg  [1:0]  shr_out_o,
    output reg  [1:0]  shr_oe_n_o,
    output reg  [3:0]  rd_data_o,
    output reg         rd_valid_o,
    output reg         io_busy_o,
    output reg         pc_load_o,
    output reg  [10:0] pc_o,
    output reg  [1:0]  flags_o,
    output reg         status_flag_o,
    output reg         irq_master_enable_o,
    output reg  [3:0]  irq_source_mask_o,
    output reg  [5:0]  irq_request_latch_o,
    output reg  [3:0]  itmr_count_o,
    output reg         core_reset_o
);
    wire core_rst;
    wire sense_lvl;
    wire sense_fall;
    wire low_lvl;
    wire low_fall;
    wire hi_fall = sense_fall;
    reg  [3:0] led_s1_q;
    reg  [3:0] led_s2_q;
    reg  [3:0] gen_s1_q;
    reg  [3:0] gen_s2_q;
    reg  [1:0] shr_s1_q;
    reg  [1:0] shr_s2_q;
    reg  [3:0] led_q;
    reg  [3:0] gen_q;
    reg  [1:0] shr_q;
    reg  [12:0] stack_q [0:`IRP_STACK_DEPTH-1];
    reg  [3:0] sp_q;
    reg  [1:0] io_op_q;
    reg  [4:0] io_addr_q;
    reg  [3:0] io_data_q;
    reg  [1:0] io_bit_q;
    reg        io_bval_q;
    reg        io_second_q;
    reg  [1:0] phase_q;
    reg  [5:0] il_set;
    reg  [5:0] pend;
    reg  [2:0] win;
    reg  [10:0] vec;
    reg  [3:0] wval;
    reg  [3:0] cur;

    irp_reset_qual u_rq (
        .clk_i         (clk_i),
        .reset_i       (reset_i),
        .reset_pin_n_i (reset_pin_n_i),
        .core_rst_o    (core_rst)
    );
    irp_sync_edge u_sense (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .pin_i   (sense_pin_i),
        .level_o (sense_lvl),
        .fall_o  (sense_fall)
    );
    irp_sync_edge u_low (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .pin_i   (shr_pin_i[0]),
        .level_o (low_lvl),
        .fall_o  (low_fall)
    );

    // request sources and priority pick
    always @* begin
        il_set = 6'h00;
        il_set[`IRP_IL_HIGH] = hi_fall; // RULE7
        il_set[`IRP_IL_TC1]  = tc1_ovf_i;
        il_set[`IRP_IL_TC2]  = tc2_ovf_i;
        il_set[`IRP_IL_ITMR] = itmr_tick_i;
        il_set[`IRP_IL_LOW]  = low_fall; // RULE4
        pend = 6'h00;
        pend[`IRP_IL_HIGH] = irq_request_latch_o[`IRP_IL_HIGH]; // RULE6
        pend[`IRP_IL_TC1]  = irq_request_latch_o[`IRP_IL_TC1] & irq_source_mask_o[2];
        pend[`IRP_IL_TC2]  = irq_request_latch_o[`IRP_IL_TC2] & irq_source_mask_o[1];
        pend[`IRP_IL_ITMR] = irq_request_latch_o[`IRP_IL_ITMR] & irq_source_mask_o[1];
        pend[`IRP_IL_LOW]  = irq_request_latch_o[`IRP_IL_LOW] & irq_source_mask_o[0];
        win = 3'd`IRP_IL_LOW;
        vec = `IRP_VEC_LOW;
        if (pend[`IRP_IL_HIGH]) begin
            win = 3'd`IRP_IL_HIGH;
            vec = `IRP_VEC_HIGH;
        end else if (pend[`IRP_IL_TC1]) begin
            win = 3'd`IRP_IL_TC1;
            vec = `IRP_VEC_TC1;
        end else if (pend[`IRP_IL_TC2]) begin
            win = 3'd`IRP_IL_TC2;
            vec = `IRP_VEC_TC2;
        end else if (pend[`IRP_IL_ITMR]) begin
            win = 3'd`IRP_IL_ITMR;
            vec = `IRP_VEC_ITMR;
        end
    end

    // output value for the current port write
    always @* begin
        case (io_addr_q)
            `IRP_ADDR_LED: cur = led_q;
            `IRP_ADDR_GEN: cur = gen_q;
            `IRP_ADDR_SHR: cur = {2'h0, shr_q};
            default:       cur = 4'h0;
        endcase
        wval = io_data_q;
        if (io_op_q == `IRP_OP_BIT) begin
            wval = cur;
            wval[io_bit_q] = io_bval_q; // RULE23
        end
    end

    always @(posedge clk_i) begin
        led_s1_q <= led_pin_i;
        led_s2_q <= led_s1_q;
        gen_s1_q <= gen_pin_i;
        gen_s2_q <= gen_s1_q;
        shr_s1_q <= shr_pin_i;
        shr_s2_q <= shr_s1_q;
    end

    always @(posedge clk_i) begin
        if (reset_i || core_rst) begin
            irq_master_enable_o <= 1'b0; // RULE10
            irq_request_latch_o <= 6'h00; // RULE10
            status_flag_o       <= 1'b1; // RULE10
            irq_source_mask_o   <= 4'h0; // RULE11
            itmr_count_o        <= 4'h0; // RULE11
            pc_load_o           <= 1'b1;
            pc_o                <= `IRP_PC_RESET; // RULE9
            flags_o             <= 2'h0;
            sp_q                <= 4'h0;
            led_q               <= `IRP_PORT_RST4;
            gen_q               <= `IRP_PORT_RST4;
            shr_q               <= `IRP_PORT_RST2;
            io_op_q             <= `IRP_OP_NONE;
            io_addr_q           <= 5'h00;
            io_data_q           <= 4'h0;
            io_bit_q            <= 2'h0;
            io_bval_q           <= 1'b0;
            io_second_q         <= 1'b0;
            phase_q             <= 2'h0;
            rd_data_o           <= 4'h0;
            rd_valid_o          <= 1'b0;
            io_busy_o           <= 1'b0;
        end else begin
            pc_load_o  <= 1'b0;
            rd_valid_o <= 1'b0;
            itmr_count_o <= itmr_count_o + {3'h0, itmr_tick_i};
            if (mask_wr_i) begin
                irq_source_mask_o <= mask_data_i;
            end
            if (eif_set_i) begin
                irq_master_enable_o <= 1'b1;
            end else if (eif_clr_i) begin
                irq_master_enable_o <= 1'b0;
            end
            // software clears, hardware set wins
            irq_request_latch_o <= (irq_request_latch_o &
                                    (ilclr_i ? ilclr_keep_i : 6'h3F)) | il_set; // RULE4
            if (return_from_irq_instr_i && sp_q != 4'h0) begin
                pc_load_o           <= 1'b1;
                {pc_o, flags_o}     <= stack_q[sp_q - 4'h1]; // RULE1 RULE3
                sp_q                <= sp_q - 4'h1;
                irq_master_enable_o <= 1'b1; // RULE2
            end else if (instr_end_i && irq_master_enable_o && (|pend) && !io_busy_o) begin
                stack_q[sp_q]       <= {pc_i, flags_i}; // RULE20
                sp_q                <= sp_q + 4'h1;
                pc_load_o           <= 1'b1;
                pc_o                <= vec; // RULE20
                status_flag_o       <= 1'b1; // RULE20
                irq_master_enable_o <= 1'b0; // RULE20
                irq_request_latch_o[win] <= il_set[win]; // RULE20
            end
            // two-cycle i/o instruction, four phases after the first cycle
            if (!io_busy_o && op_i != `IRP_OP_NONE) begin
                io_busy_o   <= 1'b1;
                io_op_q     <= op_i;
                io_addr_q   <= port_addr_i; // RULE12
                io_data_q   <= wr_data_i;
                io_bit_q    <= bit_sel_i;
                io_bval_q   <= bit_val_i;
                io_second_q <= 1'b0;
                phase_q     <= 2'h0;
            end else if (io_busy_o) begin
                if (!io_second_q) begin
                    io_second_q <= 1'b1;
                end else begin
                    phase_q <= phase_q + 2'h1;
                    if (phase_q == `IRP_PH_SAMPLE && io_op_q == `IRP_OP_IN) begin // RULE13
                        rd_valid_o <= 1'b1;
                        case (io_addr_q)
                            `IRP_ADDR_LED:   rd_data_o <= led_s2_q; // RULE15
                            `IRP_ADDR_GEN:   rd_data_o <= gen_s2_q;
                            `IRP_ADDR_SHR:   rd_data_o <= {2'h0, shr_s2_q};
                            `IRP_ADDR_SENSE: rd_data_o <= {3'h0, ~sense_lvl}; // RULE21 RULE18
                            default:         rd_data_o <= 4'h0; // RULE22
                        endcase
                    end
                    if (phase_q == `IRP_PH_UPDATE) begin // RULE14
                        io_busy_o <= 1'b0;
                        if (io_op_q != `IRP_OP_IN) begin
                            case (io_addr_q)
                                `IRP_ADDR_LED: led_q <= wval; // RULE17 RULE15
                                `IRP_ADDR_GEN: gen_q <= wval; // RULE17
                                `IRP_ADDR_SHR: shr_q <= wval[1:0]; // RULE19
                                default:       led_q <= led_q; // RULE22
                            endcase
                        end
                    end
                end
            end
        end
    end

    // open-drain style pins: drive low only where latch holds zero
    always @(posedge clk_i) begin
        core_reset_o <= reset_i | core_rst;
        led_out_o    <= led_q;
        led_oe_n_o   <= led_q;
        gen_out_o    <= gen_q;
        gen_oe_n_o   <= gen_q;
        shr_out_o    <= shr_q;
        shr_oe_n_o   <= shr_q;
    end
endmodule // irp_core

/* File: test/irp_core_chk.sv */
// concurrent checks on the core ports
`timescale 1ns/1ps
module irp_core_chk (
    input wire        clk_i,
    input wire        reset_i,
    input wire [1:0]  op_i,
    input wire [4:0]  port_addr_i,
    input wire [3:0]  wr_data_i,
    input wire        instr_end_i,
    input wire        return_from_irq_instr_i,
    input wire        eif_set_i,
    input wire        sense_pin_i,
    input wire        io_busy_o,
    input wire        rd_valid_o,
    input wire [3:0]  led_out_o,
    input wire        pc_load_o,
    input wire [10:0] pc_o,
    input wire        status_flag_o,
    input wire        irq_master_enable_o,
    input wire [3:0]  irq_source_mask_o,
    input wire [5:0]  irq_request_latch_o,
    input wire        core_reset_o
);
    reg  [3:0] wd_q;
    wire       take = op_i != 2'h0 && !io_busy_o && !core_reset_o;
    wire       pend = irq_request_latch_o[5] | |(irq_request_latch_o[3:0]
                      & {irq_source_mask_o[2:1], irq_source_mask_o[1:0]});
    wire       acc  = instr_end_i && irq_master_enable_o && pend && !io_busy_o
                      && !return_from_irq_instr_i && !eif_set_i && !core_reset_o;
    always @(posedge clk_i) begin
        if (take)
            wd_q <= wr_data_i;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    chk_reset_state: assert property ($fell(reset_i) |-> status_flag_o
        && !irq_master_enable_o && irq_request_latch_o == 6'h00 && irq_source_mask_o == 4'h0)
        else $error("reset state wrong");
    chk_reset_fetch: assert property ($fell(reset_i) |-> pc_load_o && pc_o == 11'h000)
        else $error("reset fetch wrong");
    chk_read_answer: assert property (take && op_i == 2'h1 |-> ##[5:6] rd_valid_o)
        else $error("read answer missing");
    chk_busy_span: assert property (take |=> ##1 io_busy_o [*4] ##[1:2] !io_busy_o)
        else $error("busy span wrong");
    chk_write_pins: assert property (take && op_i == 2'h2 && port_addr_i == 5'h04
        |-> ##[6:7] led_out_o == wd_q)
        else $error("pins not updated");
    chk_accept_entry: assert property (acc |=> ##[0:1] pc_load_o
        && !irq_master_enable_o && status_flag_o)
        else $error("entry wrong");
    chk_high_vector: assert property (acc && irq_request_latch_o[5]
        |=> ##[0:1] pc_load_o && pc_o == 11'h002)
        else $error("vector wrong");
    chk_sense_raise: assert property ($fell(sense_pin_i) ##1 !sense_pin_i
        |-> ##[1:5] irq_request_latch_o[5])
        else $error("fall not latched");
    chk_enable_cause: assert property ($rose(irq_master_enable_o) |-> $past(return_from_irq_instr_i)
        || $past(eif_set_i) || $past(return_from_irq_instr_i, 2) || $past(eif_set_i, 2))
        else $error("enable rose alone");
endmodule // irp_core_chk

/* File: test/irp_pin_model.sv */
// outside circuits on the three bidirectional ports
`timescale 1ns/1ps
module irp_pin_model (
    input  wire [3:0] led_out_i,
    input  wire [3:0] led_oe_n_i,
    input  wire [3:0] gen_out_i,
    input  wire [3:0] gen_oe_n_i,
    input  wire [3:0] gen_ext_i,
    input  wire [1:0] shr_out_i,
    input  wire [1:0] shr_oe_n_i,
    output wire [3:0] led_pin_o,
    output wire [3:0] gen_pin_o,
    output wire [1:0] shr_pin_o
);
    // driven bits follow the core, others the steady outside level
    assign led_pin_o = led_oe_n_i | led_out_i;
    assign gen_pin_o = (gen_oe_n_i & gen_ext_i) | (~gen_oe_n_i & gen_out_i);
    assign shr_pin_o = shr_oe_n_i | shr_out_i;
endmodule // irp_pin_model

/* File: test/tb.sv */
// self-checking bench for the interrupt, reset and port core
`timescale 1ns/1ps
module tb;
    typedef struct packed {logic [13:0] cmd; logic [3:0] e; logic [3:0] m;} irp_row_t;
    logic clk_i = 1'b0, reset_i = 1'b1, reset_pin_n_i = 1'b1, bit_val_i = 1'b0;
    logic instr_end_i = 1'b0, return_from_irq_instr_i = 1'b0, eif_set_i = 1'b0, eif_clr_i = 1'b0;
    logic mask_wr_i = 1'b0, sense_pin_i = 1'b1, tc1_ovf_i = 1'b0;
    logic [1:0] op_i = 2'h0, bit_sel_i = 2'h0, flags_i = 2'h0;
    logic [4:0] port_addr_i = 5'h00;
    logic [3:0] wr_data_i = 4'h0, mask_data_i = 4'h0;
    logic [10:0] pc_i = 11'h000;
    wire [3:0] led_pin_i, gen_pin_i, led_out_o, led_oe_n_o, gen_out_o, gen_oe_n_o;
    wire [3:0] rd_data_o, irq_source_mask_o;
    wire [1:0] shr_pin_i, shr_out_o, shr_oe_n_o, flags_o;
    wire [10:0] pc_o;
    wire [5:0] irq_request_latch_o;
    wire rd_valid_o, io_busy_o, pc_load_o, status_flag_o, irq_master_enable_o, core_reset_o;
    int errors = 0, total_checks = 0, cyc = 0;
    irp_row_t rows [15] = '{
        '{{2'h1, 5'h05, 7'h00}, 4'h6, 4'hF}, '{{2'h2, 5'h04, 7'h50}, 4'h0, 4'h0},
        '{{2'h1, 5'h04, 7'h00}, 4'hA, 4'hF}, '{{2'h2, 5'h05, 7'h18}, 4'h0, 4'h0},
        '{{2'h1, 5'h05, 7'h00}, 4'h2, 4'hF}, '{{2'h3, 5'h04, 7'h01}, 4'h0, 4'h0},
        '{{2'h1, 5'h04, 7'h00}, 4'hB, 4'hF}, '{{2'h2, 5'h08, 7'h10}, 4'h0, 4'h0},
        '{{2'h1, 5'h08, 7'h00}, 4'h2, 4'h3}, '{{2'h3, 5'h08, 7'h02}, 4'h0, 4'h0},
        '{{2'h1, 5'h08, 7'h00}, 4'h0, 4'h3}, '{{2'h2, 5'h06, 7'h00}, 4'h0, 4'h0},
        '{{2'h1, 5'h04, 7'h00}, 4'hB, 4'hF}, '{{2'h1, 5'h06, 7'h00}, 4'h0, 4'hF},
        '{{2'h1, 5'h0E, 7'h00}, 4'h0, 4'h1}};
    irp_core dut (.clk_i, .reset_i, .reset_pin_n_i, .op_i, .port_addr_i, .wr_data_i, .bit_sel_i,
        .bit_val_i, .instr_end_i, .return_from_irq_instr_i, .pc_i, .flags_i, .ilclr_i(1'b0), .ilclr_keep_i(6'h3F),
        .eif_set_i, .eif_clr_i, .mask_wr_i, .mask_data_i, .tc1_ovf_i, .tc2_ovf_i(1'b0),
        .itmr_tick_i(1'b0), .led_pin_i, .gen_pin_i, .shr_pin_i, .sense_pin_i, .led_out_o,
        .led_oe_n_o, .gen_out_o, .gen_oe_n_o, .shr_out_o, .shr_oe_n_o, .rd_data_o, .rd_valid_o,
        .io_busy_o, .pc_load_o, .pc_o, .flags_o, .status_flag_o, .irq_master_enable_o,
        .irq_source_mask_o, .irq_request_latch_o, .itmr_count_o(), .core_reset_o);
    irp_pin_model pins (.led_out_i(led_out_o), .led_oe_n_i(led_oe_n_o), .gen_out_i(gen_out_o),
        .gen_oe_n_i(gen_oe_n_o), .gen_ext_i(4'h6), .shr_out_i(shr_out_o),
        .shr_oe_n_i(shr_oe_n_o), .led_pin_o(led_pin_i), .gen_pin_o(gen_pin_i),
        .shr_pin_o(shr_pin_i));
    always #12.5 clk_i = ~clk_i;
    task automatic conclude;
        if (errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic io(input irp_row_t r);
        int v;
        v = 0;
        @(posedge clk_i);
        {op_i, port_addr_i, wr_data_i, bit_sel_i, bit_val_i} <= r.cmd;
        @(posedge clk_i);
        op_i <= 2'h0;
        repeat (9) begin
            @(negedge clk_i);
            if (rd_valid_o === 1'b1)
                v++;
        end
        check("rd_valid", 16'(v), {15'h0, r.cmd[13:12] == 2'h1});
        if (r.cmd[13:12] == 2'h1)
            check("rd_data", {12'h0, rd_data_o & r.m}, {12'h0, r.e});
    endtask
    task automatic step(input logic ie);
        int n;
        n = 0;
        @(posedge clk_i);
        instr_end_i <= ie;
        return_from_irq_instr_i <= !ie;
        @(posedge clk_i);
        instr_end_i <= 1'b0;
        return_from_irq_instr_i <= 1'b0;
        @(negedge clk_i);
        while (pc_load_o !== 1'b1 && n < 4) begin
            @(negedge clk_i);
            n++;
        end
        check("pc_load", {15'h0, pc_load_o}, 16'h0001);
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            errors++;
            conclude();
        end
    end
    initial begin
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        foreach (rows[i])
            io(rows[i]);
        @(posedge clk_i);
        eif_set_i <= 1'b1;
        pc_i <= 11'h123;
        flags_i <= 2'h2;
        @(posedge clk_i);
        eif_set_i <= 1'b0;
        sense_pin_i <= 1'b0;
        repeat (8) @(negedge clk_i);
        check("latch_high", {15'h0, irq_request_latch_o[5]}, 16'h0001);
        step(1'b1);
        check("entry", {pc_o, irq_master_enable_o, status_flag_o, irq_request_latch_o[5]},
            {11'h002, 3'h2});
        step(1'b0);
        check("return", {pc_o, flags_o, irq_master_enable_o}, {11'h123, 2'h2, 1'b1});
        @(posedge clk_i);
        eif_clr_i <= 1'b1;
        mask_wr_i <= 1'b1;
        mask_data_i <= 4'h5;
        @(posedge clk_i);
        eif_clr_i <= 1'b0;
        mask_wr_i <= 1'b0;
        reset_pin_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_pin_n_i <= 1'b1;
        repeat (6) @(negedge clk_i);
        check("short_low", {irq_source_mask_o, irq_master_enable_o}, 16'h000A);
        @(posedge clk_i);
        reset_pin_n_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        reset_pin_n_i <= 1'b1;
        repeat (6) @(negedge clk_i);
        check("pin_reset", {irq_source_mask_o, status_flag_o, led_out_o}, 16'h001F);
        @(posedge clk_i);
        mask_wr_i <= 1'b1;
        eif_set_i <= 1'b1;
        sense_pin_i <= 1'b1;
        tc1_ovf_i <= 1'b1;
        @(posedge clk_i);
        mask_wr_i <= 1'b0;
        eif_set_i <= 1'b0;
        tc1_ovf_i <= 1'b0;
        reset_i <= 1'b1;
        @(negedge clk_i);
        check("latch_tc1", {15'h0, irq_request_latch_o[3]}, 16'h0001);
        @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (2) @(negedge clk_i);
        check("reset", {irq_source_mask_o, irq_master_enable_o, status_flag_o, irq_request_latch_o},
            {4'h0, 2'h1, 6'h00});
        conclude();
    end
endmodule // tb
bind irp_core irp_core_chk chk (.clk_i, .reset_i, .op_i, .port_addr_i, .wr_data_i, .instr_end_i,
    .return_from_irq_instr_i, .eif_set_i, .sense_pin_i, .io_busy_o, .rd_valid_o, .led_out_o, .pc_load_o, .pc_o,
    .status_flag_o, .irq_master_enable_o, .irq_source_mask_o, .irq_request_latch_o, .core_reset_o);
